// ---- src/svc_top.sv ----
// servo command interpreter and sequencer with wishbone registers
// Contract
// R01: format reference targets 64 tracks, normal reference 72 tracks from inner stop.
// R02: park leaves heads undetented at the inner stop, off the data zones.
// R03: after a seek, an offset flagged in the command is performed at once.
// R04: servo fault starts a short recovery reference, at most two attempts; here only a fault in ST_MOVE, or in ST_COMM/ST_FCOMM with positioner ready.
// R05: successful recovery shows positioner ready, link ready and fault all active.
// R06: two failed recovery attempts end with a park.
// R07: offset byte bit 6 selects explicit (0) or embedded-correction (1) offset.
// R08: explicit offset bit 7 gives direction: 1 toward spindle, 0 reverse.
// R09: explicit offset microsteps the fine loop by the commanded amount.
// R10: embedded correction samples position error and applies it only at index.
// R11: correction held, optionally refreshed at index, until offset, seek or reference.
// R12: track following keeps heads detented and ready for another command; here detent_o drops while a status answer is sent (ST_TX).
// R13: commands start only from a communication state; none accepted elsewhere.
// R14: communication state after reset and after settling of every operation.
// R15: after a servo fault a separate fault communication state still takes commands.
// R16: controller stays silent while serial link ready is inactive.
// R17: every command is five bytes, all assembled before acting.
// R18: second byte is the low-order track difference of a seek.
// R19: bytes carry command code, offset control and status/diagnostic selection.
// R20: fifth byte is a check over the first four.
// R21: check byte is the modulo-256 sum of complements of bytes one to four.
// R22: code set; seek and offset need positioner ready and no fault.
// R23: controller samples fault 250 us after the last byte to see rejection.
// R24: link ready drops while a command runs, returns in communication state.
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module svc_top #(
  parameter int unsigned CLKS_PER_BIT = svc_pkg::BIT_CYC,
  parameter int unsigned SETTLE_CYCLES = svc_pkg::SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_rx_i,
  output logic serial_tx_o,
  output svc_pkg::svc_lines_t status_o,
  input wire logic servo_fault_i,
  input wire logic move_done_i,
  input wire logic move_fail_i,
  input wire logic index_i,
  input wire logic [7:0] position_error_i,
  output logic move_start_o,
  output svc_pkg::svc_move_t move_o,
  output logic detent_o,
  output logic offset_step_o,
  output logic offset_dir_o,
  output logic [4:0] offset_amount_o,
  output logic [7:0] correction_o,
  output logic correction_valid_o
);
  typedef enum logic [7:0] {
    ST_COMM = 8'h01,
    ST_FCOMM = 8'h02,
    ST_MOVE = 8'h04,
    ST_OFS = 8'h08,
    ST_RECOV = 8'h10,
    ST_PARK = 8'h20,
    ST_SETTLE = 8'h40,
    ST_TX = 8'h80
  } svc_state_t;

  localparam logic [15:0] SETTLE_M1 = 16'(SETTLE_CYCLES - 1);

  svc_state_t state_reg;
  svc_pkg::svc_cmd_t frame_reg, cmd_reg;
  logic [2:0] byte_cnt_reg, tx_idx_reg;
  logic [1:0] tries_reg;
  logic [15:0] settle_reg;
  logic pos_ready_reg, fault_reg, ctrl_refresh_reg, parked_reg;
  logic [3:0] pin_s1_reg, pin_s2_reg, pin_d_reg;
  logic [7:0] pes_s1_reg, pes_s2_reg, status_snap_reg, tx_data;
  logic [7:0] rx_data;
  logic rx_valid, tx_ready, tx_valid;
  logic in_comm, frame_go, frame_ok, is_seek, needs_pos, known, allowed;
  logic cmd_good, cmd_bad, fault_rise, done_rise, fail_rise, index_rise;

  // ==========================================================
  // serial link
  svc_serial #(
    .CLKS_PER_BIT(CLKS_PER_BIT)
  ) u_serial (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rxd_i(serial_rx_i),
    .txd_o(serial_tx_o),
    .rx_data_o(rx_data),
    .rx_valid_o(rx_valid),
    .tx_data_i(tx_data),
    .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready)
  );

  // ==========================================================
  // pin synchronisers and edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      pin_d_reg <= 4'h0;
      pes_s1_reg <= 8'h00;
      pes_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= {servo_fault_i, move_done_i, move_fail_i, index_i};
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg <= pin_s2_reg;
      pes_s1_reg <= position_error_i;
      pes_s2_reg <= pes_s1_reg;
    end
  end

  assign fault_rise = pin_s2_reg[3] & ~pin_d_reg[3];
  assign done_rise = pin_s2_reg[2] & ~pin_d_reg[2];
  assign fail_rise = pin_s2_reg[1] & ~pin_d_reg[1];
  assign index_rise = pin_s2_reg[0] & ~pin_d_reg[0];

  // ==========================================================
  // command assembly and decode
  assign in_comm = (state_reg == ST_COMM) || (state_reg == ST_FCOMM);
  assign frame_go = rx_valid && in_comm && (byte_cnt_reg == 3'(svc_pkg::FRAME_BYTES - 1)); // R17
  assign frame_ok = (svc_pkg::svc_check(frame_reg) == rx_data); // R20 R21
  assign is_seek = (frame_reg.code[7:4] == svc_pkg::CODE_SEEK_HI) ||
                   (frame_reg.code[7:4] == svc_pkg::CODE_SEEK_OFS_HI);
  assign needs_pos = is_seek || (frame_reg.code == svc_pkg::CODE_OFFSET);
  assign known = is_seek || (frame_reg.code inside {svc_pkg::CODE_REF_DATA,
                 svc_pkg::CODE_REF_FMT, svc_pkg::CODE_PARK, svc_pkg::CODE_OFFSET,
                 svc_pkg::CODE_STATUS}); // R22
  assign allowed = !needs_pos || (pos_ready_reg && !fault_reg); // R22
  assign cmd_bad = frame_go && !(frame_ok && known && allowed);
  assign cmd_good = frame_go && frame_ok && known && allowed;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      byte_cnt_reg <= 3'h0;
      frame_reg <= '0;
    end else if (!in_comm) begin
      byte_cnt_reg <= 3'h0; // R13
    end else if (rx_valid) begin
      case (byte_cnt_reg)
        3'h0: frame_reg.code <= rx_data; // R19
        3'h1: frame_reg.diff <= rx_data; // R18
        3'h2: frame_reg.ofs <= rx_data; // R19
        3'h3: frame_reg.diag <= rx_data; // R19
        default: frame_reg <= frame_reg;
      endcase
      byte_cnt_reg <= frame_go ? 3'h0 : byte_cnt_reg + 3'h1; // R17
    end
  end

  // ==========================================================
  // fault line: set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_reg <= 1'b0;
    end else if (cmd_bad || fault_rise || (state_reg == ST_MOVE && fail_rise)) begin
      fault_reg <= 1'b1; // R23
    end else if (cmd_good && (frame_reg.code inside {svc_pkg::CODE_STATUS,
                              svc_pkg::CODE_REF_DATA, svc_pkg::CODE_REF_FMT})) begin
      fault_reg <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_COMM; // R14
      cmd_reg <= '0;
      tries_reg <= 2'd0;
      settle_reg <= 16'h0000;
      pos_ready_reg <= 1'b0;
      parked_reg <= 1'b0;
      move_start_o <= 1'b0;
      move_o <= '{kind: svc_pkg::SVC_MV_SEEK, tracks: 12'h000};
      offset_step_o <= 1'b0;
      offset_dir_o <= 1'b0;
      offset_amount_o <= 5'h00;
      tx_idx_reg <= 3'h0;
      status_snap_reg <= 8'h00;
    end else begin
      move_start_o <= 1'b0;
      offset_step_o <= 1'b0;
      case (state_reg)
        ST_COMM, ST_FCOMM: begin
          if (cmd_good) begin // R13
            cmd_reg <= frame_reg;
            move_start_o <= is_seek || (frame_reg.code inside {svc_pkg::CODE_REF_DATA,
                            svc_pkg::CODE_REF_FMT, svc_pkg::CODE_PARK});
            state_reg <= ST_MOVE;
            if (is_seek) begin
              move_o <= '{kind: svc_pkg::SVC_MV_SEEK,
                          tracks: {frame_reg.code[3:0], frame_reg.diff}}; // R18
            end else if (frame_reg.code == svc_pkg::CODE_REF_DATA) begin
              move_o <= '{kind: svc_pkg::SVC_MV_REF_DATA,
                          tracks: svc_pkg::REF_DATA_TRACKS}; // R01
            end else if (frame_reg.code == svc_pkg::CODE_REF_FMT) begin
              move_o <= '{kind: svc_pkg::SVC_MV_REF_FMT,
                          tracks: svc_pkg::REF_FMT_TRACKS}; // R01
            end else if (frame_reg.code == svc_pkg::CODE_PARK) begin
              move_o <= '{kind: svc_pkg::SVC_MV_PARK, tracks: 12'h000}; // R02
              pos_ready_reg <= 1'b0;
            end else if (frame_reg.code == svc_pkg::CODE_OFFSET) begin
              state_reg <= ST_OFS;
            end else begin
              status_snap_reg <= {4'h0, parked_reg, pos_ready_reg, fault_reg, 1'b1};
              tx_idx_reg <= 3'h0;
              state_reg <= ST_TX;
            end
          end else if (fault_rise && pos_ready_reg) begin
            tries_reg <= 2'd1; // R04
            pos_ready_reg <= 1'b0;
            move_start_o <= 1'b1;
            move_o <= '{kind: svc_pkg::SVC_MV_RECOV, tracks: svc_pkg::REF_DATA_TRACKS};
            state_reg <= ST_RECOV;
          end
        end
        ST_MOVE: begin
          if (move_o.kind == svc_pkg::SVC_MV_PARK && (done_rise || fail_rise)) begin
            parked_reg <= 1'b1; // R02
            settle_reg <= SETTLE_M1;
            state_reg <= ST_SETTLE;
          end else if (fail_rise || fault_rise) begin
            tries_reg <= 2'd1; // R04
            pos_ready_reg <= 1'b0;
            move_start_o <= 1'b1;
            move_o <= '{kind: svc_pkg::SVC_MV_RECOV, tracks: svc_pkg::REF_DATA_TRACKS};
            state_reg <= ST_RECOV;
          end else if (done_rise) begin
            pos_ready_reg <= 1'b1;
            parked_reg <= 1'b0;
            settle_reg <= SETTLE_M1;
            if (move_o.kind == svc_pkg::SVC_MV_SEEK &&
                cmd_reg.code[svc_pkg::SEEK_OFS_BIT]) begin
              state_reg <= ST_OFS; // R03
            end else begin
              state_reg <= ST_SETTLE;
            end
          end
        end
        ST_OFS: begin
          settle_reg <= SETTLE_M1;
          if (!cmd_reg.ofs[svc_pkg::OFS_AUTO_BIT]) begin // R07
            offset_step_o <= 1'b1; // R09
            offset_dir_o <= cmd_reg.ofs[svc_pkg::OFS_DIR_BIT]; // R08
            offset_amount_o <= cmd_reg.ofs[4:0]; // R09
            state_reg <= ST_SETTLE;
          end else if (index_rise) begin
            state_reg <= ST_SETTLE; // R10
          end
        end
        ST_RECOV: begin
          if (done_rise) begin
            pos_ready_reg <= 1'b1; // R05
            parked_reg <= 1'b0;
            settle_reg <= SETTLE_M1;
            state_reg <= ST_SETTLE;
          end else if (fail_rise) begin
            move_start_o <= 1'b1;
            if (tries_reg == svc_pkg::RECOV_TRIES) begin
              move_o <= '{kind: svc_pkg::SVC_MV_PARK, tracks: 12'h000}; // R06
              state_reg <= ST_PARK;
            end else begin
              tries_reg <= tries_reg + 2'd1; // R04
            end
          end
        end
        ST_PARK: begin
          if (done_rise || fail_rise) begin
            parked_reg <= 1'b1; // R06
            settle_reg <= SETTLE_M1;
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (settle_reg != 16'h0000) begin
            settle_reg <= settle_reg - 16'h0001;
          end else begin
            state_reg <= fault_reg ? ST_FCOMM : ST_COMM; // R14 R15
          end
        end
        ST_TX: begin
          if (tx_ready) begin
            if (tx_idx_reg == 3'(svc_pkg::FRAME_BYTES)) begin
              settle_reg <= SETTLE_M1;
              state_reg <= ST_SETTLE; // R14
            end else begin
              tx_idx_reg <= tx_idx_reg + 3'h1;
            end
          end
        end
        default: state_reg <= ST_COMM;
      endcase
    end
  end

  // ==========================================================
  // status answer bytes
  svc_pkg::svc_cmd_t reply;
  assign reply = '{code: status_snap_reg, diff: correction_o,
                   ofs: cmd_reg.code, diag: {6'h00, tries_reg}};
  assign tx_valid = (state_reg == ST_TX) && (tx_idx_reg != 3'(svc_pkg::FRAME_BYTES));

  always_comb begin
    case (tx_idx_reg)
      3'h0: tx_data = reply.code;
      3'h1: tx_data = reply.diff;
      3'h2: tx_data = reply.ofs;
      3'h3: tx_data = reply.diag;
      default: tx_data = svc_pkg::svc_check(reply);
    endcase
  end

  // ==========================================================
  // embedded correction, held between index times
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      correction_o <= 8'h00;
      correction_valid_o <= 1'b0;
    end else if (state_reg == ST_OFS && cmd_reg.ofs[svc_pkg::OFS_AUTO_BIT] && index_rise) begin
      correction_o <= pes_s2_reg; // R10
      correction_valid_o <= 1'b1;
    end else if (cmd_good && (needs_pos || frame_reg.code == svc_pkg::CODE_REF_DATA ||
                              frame_reg.code == svc_pkg::CODE_REF_FMT)) begin
      correction_o <= 8'h00; // R11
      correction_valid_o <= 1'b0;
    end else if (ctrl_refresh_reg && correction_valid_o && in_comm && index_rise) begin
      correction_o <= pes_s2_reg; // R11
    end
  end

  // ==========================================================
  // status lines
  assign status_o = '{link_ready: in_comm, pos_ready: pos_ready_reg, fault: fault_reg}; // R24 R05
  assign detent_o = pos_ready_reg && !parked_reg &&
                    (in_comm || state_reg == ST_OFS || state_reg == ST_SETTLE); // R12 R02

  // ==========================================================
  // wishbone slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_refresh_reg <= svc_pkg::CTRL_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == svc_pkg::ADR_CTRL) begin
          ctrl_refresh_reg <= wb_dat_i[svc_pkg::CTRL_REFRESH_BIT];
        end
        case (wb_adr_i)
          svc_pkg::ADR_CTRL: wb_dat_o <= {31'h0, ctrl_refresh_reg};
          svc_pkg::ADR_STATUS: wb_dat_o <= {16'h0000, state_reg, 2'h0, tries_reg,
                                            parked_reg, status_o};
          svc_pkg::ADR_LASTCMD: wb_dat_o <= cmd_reg;
          svc_pkg::ADR_CORR: wb_dat_o <= {23'h0, correction_valid_o, correction_o};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- src/svc_pkg.sv ----
// shared constants and types of the servo command interpreter
package svc_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD = 19_200;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned SETTLE_US = 100;
  localparam int unsigned SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);

  // ==========================================================
  // command string
  localparam int unsigned FRAME_BYTES = 5;
  localparam logic [3:0] CODE_SEEK_HI = 4'h8;
  localparam logic [3:0] CODE_SEEK_OFS_HI = 4'h9;
  localparam logic [7:0] CODE_REF_DATA = 8'h40;
  localparam logic [7:0] CODE_REF_FMT = 8'h70;
  localparam logic [7:0] CODE_PARK = 8'hc9;
  localparam logic [7:0] CODE_OFFSET = 8'h10;
  localparam logic [7:0] CODE_STATUS = 8'h00;
  localparam int unsigned OFS_DIR_BIT = 7;
  localparam int unsigned OFS_AUTO_BIT = 6;
  localparam int unsigned SEEK_OFS_BIT = 4;

  // ==========================================================
  // reference targets, tracks from inner stop, and recovery attempts
  localparam logic [11:0] REF_DATA_TRACKS = 12'd72;
  localparam logic [11:0] REF_FMT_TRACKS = 12'd64;
  localparam logic [1:0] RECOV_TRIES = 2'd2;

  // ==========================================================
  // register map
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_LASTCMD = 8'h08;
  localparam logic [7:0] ADR_CORR = 8'h0c;
  localparam int unsigned CTRL_REFRESH_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SVC_MV_SEEK = 3'h0,
    SVC_MV_REF_DATA = 3'h1,
    SVC_MV_REF_FMT = 3'h2,
    SVC_MV_RECOV = 3'h3,
    SVC_MV_PARK = 3'h4
  } svc_move_kind_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] diff;
    logic [7:0] ofs;
    logic [7:0] diag;
  } svc_cmd_t;

  typedef struct packed {
    logic link_ready;
    logic pos_ready;
    logic fault;
  } svc_lines_t;

  typedef struct packed {
    svc_move_kind_t kind;
    logic [11:0] tracks;
  } svc_move_t;

  // check byte: sum of complements of bytes one to four
  function automatic logic [7:0] svc_check(input svc_cmd_t c);
    svc_check = 8'(~c.code + ~c.diff + ~c.ofs + ~c.diag);
  endfunction

endpackage

// ---- src/svc_serial.sv ----
// 8n1 serial receiver and transmitter of the command link
`timescale 1ns/100ps
`default_nettype none
module svc_serial #(
  parameter int unsigned CLKS_PER_BIT = svc_pkg::BIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rxd_i,
  output logic txd_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  localparam logic [15:0] BIT_M1 = 16'(CLKS_PER_BIT - 1);
  localparam logic [15:0] HALF = 16'(CLKS_PER_BIT / 2);

  logic rx_s1_reg, rx_s2_reg, rx_busy_reg;
  logic [15:0] rx_cnt_reg, tx_cnt_reg;
  logic [3:0] rx_bit_reg, tx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic [9:0] tx_sh_reg;

  // ==========================================================
  // receive
  always_ff @(posedge clk_i) begin
    rx_s1_reg <= rst_i ? 1'b1 : rxd_i;
    rx_s2_reg <= rst_i ? 1'b1 : rx_s1_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (!rx_busy_reg) begin
        if (!rx_s2_reg) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= HALF;
          rx_bit_reg <= 4'h0;
        end
      end else if (rx_cnt_reg != 16'h0000) begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end else begin
        rx_cnt_reg <= BIT_M1;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0) begin
          if (rx_s2_reg) rx_busy_reg <= 1'b0;
        end else if (rx_bit_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          if (rx_s2_reg) begin
            rx_data_o <= rx_sh_reg;
            rx_valid_o <= 1'b1;
          end
        end else begin
          rx_sh_reg <= {rx_s2_reg, rx_sh_reg[7:1]};
        end
      end
    end
  end

  // ==========================================================
  // transmit
  assign tx_ready_o = (tx_bit_reg == 4'h0);
  assign txd_o = tx_sh_reg[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_sh_reg <= 10'h3ff;
      tx_cnt_reg <= 16'h0000;
      tx_bit_reg <= 4'h0;
    end else if (tx_bit_reg == 4'h0) begin
      if (tx_valid_i) begin
        tx_sh_reg <= {1'b1, tx_data_i, 1'b0};
        tx_cnt_reg <= BIT_M1;
        tx_bit_reg <= 4'ha;
      end
    end else if (tx_cnt_reg != 16'h0000) begin
      tx_cnt_reg <= tx_cnt_reg - 16'h0001;
    end else begin
      tx_cnt_reg <= BIT_M1;
      tx_bit_reg <= tx_bit_reg - 4'h1;
      tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
    end
  end
endmodule
`default_nettype wire

// ---- tb/svc_monitor.sv ----
// assertions on the servo command interpreter ports
`timescale 1ns/100ps
`default_nettype none
module svc_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic index_i,
  input wire svc_pkg::svc_lines_t status_o,
  input wire logic move_start_o,
  input wire svc_pkg::svc_move_t move_o,
  input wire logic detent_o,
  input wire logic offset_step_o,
  input wire logic correction_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // sequences
  sequence s_busy;
    !status_o.link_ready [*8];
  endsequence
  sequence s_idx;
    $past(index_i, 2) || $past(index_i, 3) || $past(index_i, 4) || $past(index_i, 5);
  endsequence
  // ==========================================================
  // properties
  AST_REF_DATA: assert property (move_start_o && move_o.kind inside
    {svc_pkg::SVC_MV_REF_DATA, svc_pkg::SVC_MV_RECOV} |-> move_o.tracks == 12'h048)
    else $error("reference target not 72");
  AST_REF_FMT: assert property (move_start_o && move_o.kind == svc_pkg::SVC_MV_REF_FMT
    |-> move_o.tracks == 12'h040) else $error("format target not 64");
  AST_LINK_DROP: assert property (move_start_o |-> !status_o.link_ready)
    else $error("link ready during move start");
  AST_BUSY_HOLD: assert property (move_start_o |-> s_busy)
    else $error("link ready back too soon");
  AST_START_COMM: assert property (move_start_o && move_o.kind < svc_pkg::SVC_MV_RECOV
    |-> $past(status_o.link_ready)) else $error("move started outside comm");
  AST_CORR_INDEX: assert property ($rose(correction_valid_o) |-> s_idx)
    else $error("correction without index");
  AST_DETENT: assert property (status_o.pos_ready && status_o.link_ready |-> detent_o)
    else $error("not detented while ready");
  AST_STEP_ONE: assert property (offset_step_o |=> !offset_step_o)
    else $error("offset step longer than one cycle");
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
endmodule
`default_nettype wire

// ---- tb/svc_ctrl_model.sv ----
// drive controller model sending command strings
`timescale 1ns/100ps
`default_nettype none
module svc_ctrl_model #(
  parameter int BIT = 16
) (
  input wire logic clk_i,
  input wire logic link_ready_i,
  input wire logic go_i,
  input wire svc_pkg::svc_cmd_t cmd_i,
  input wire logic bad_i,
  output logic txd_o,
  output logic busy_o
);
  logic [39:0] frm;
  initial txd_o = 1'b1;
  initial busy_o = 1'b0;
  always @(posedge clk_i) begin
    if (go_i && !busy_o) begin
      busy_o <= 1'b1;
      while (!link_ready_i) @(posedge clk_i);
      // bad_i spoils the check byte on purpose
      frm = {cmd_i, 8'(~cmd_i.code + ~cmd_i.diff + ~cmd_i.ofs + ~cmd_i.diag + bad_i)};
      for (int i = 4; i >= 0; i--) begin
        for (int b = 0; b < 10; b++) begin
          txd_o <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : frm[i * 8 + b - 1];
          repeat (BIT) @(posedge clk_i);
        end
      end
      busy_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_servo_command_interpreter.sv ----
// self-checking testbench of the servo command interpreter
`timescale 1ns/100ps
`default_nettype none
module test_servo_command_interpreter;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, position_error_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf, ev_in = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, r, seed = 32'h52a5;
  logic wb_ack_o, serial_rx_i, serial_tx_o, move_start_o, detent_o, offset_step_o;
  logic servo_fault_i, move_done_i, move_fail_i, index_i, offset_dir_o, correction_valid_o;
  logic [4:0] offset_amount_o;
  logic [7:0] correction_o;
  logic go = 1'b0, bad = 1'b0, busy;
  svc_pkg::svc_lines_t status_o;
  svc_pkg::svc_move_t move_o;
  svc_pkg::svc_cmd_t c;
  int mismatches = 0, num_checks = 0;
  assign {index_i, move_fail_i, move_done_i, servo_fault_i} = ev_in;
  always #5 clk_i = ~clk_i;
  svc_top #(.CLKS_PER_BIT(16), .SETTLE_CYCLES(8)) i_dut (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .serial_rx_i, .serial_tx_o, .status_o, .servo_fault_i, .move_done_i, .move_fail_i,
    .index_i, .position_error_i, .move_start_o, .move_o, .detent_o, .offset_step_o,
    .offset_dir_o, .offset_amount_o, .correction_o, .correction_valid_o);
  svc_ctrl_model i_ctrl (.clk_i, .link_ready_i(status_o.link_ready), .go_i(go),
    .cmd_i(c), .bad_i(bad), .txd_o(serial_rx_i), .busy_o(busy));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [11:0] exp_trk(input svc_pkg::svc_cmd_t v);
    return {v.code[3:0], v.diff};
  endfunction
  function logic ev(input int k);
    case (k)
      0: return move_start_o;
      1: return status_o.link_ready;
      2: return offset_step_o;
      3: return correction_valid_o;
      4: return !busy;
      5: return !status_o.link_ready;
      6: return busy;
      7: return !serial_tx_o;
      default: return wb_ack_o;
    endcase
  endfunction
  task end_of_test();
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task wait_ev(input int k);
    int n;
    for (n = 0; n < 4000 && ev(k) !== 1'b1; n++) @(posedge clk_i);
    if (n == 4000) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    wait_ev(8);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task send(input svc_pkg::svc_cmd_t v, input logic b);
    wait_ev(4);
    {c, bad, go} <= {v, b, 1'b1};
    wait_ev(6);
    go <= 1'b0;
  endtask
  task pulse(input int k);
    ev_in[k] <= 1'b1;
    @(posedge clk_i);
    ev_in <= 4'h0;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("lines", 32'h4, status_o);
    wb(1'b0, svc_pkg::ADR_STATUS, 32'h0);
    chk("status reg", 32'h104, rd);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, svc_pkg::ADR_CTRL, 32'h1);
    wb(1'b0, svc_pkg::ADR_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      c = {i < 2 ? (i ? 8'h70 : 8'h40) : {3'h4, i == 5, r[3:0]}, r[15:8], r[23], 2'h0, r[20:16], 8'h00};
      send(c, 1'b0);
      wait_ev(0);
      if (i < 2) chk("ref", i ? 32'h2040 : 32'h1048, move_o);
      else chk("seek", {3'h0, exp_trk(c)}, move_o);
      chk("busy", 32'h0, status_o.link_ready);
      pulse(1);
      if (i == 5) wait_ev(2);
      if (i == 5) chk("offset", {c.ofs[7], c.ofs[4:0]}, {offset_dir_o, offset_amount_o});
      wait_ev(1);
      chk("ready", 32'h6, status_o);
      chk("detent", 32'h1, detent_o);
    end
    send({8'h10, 8'h00, 8'h40, 8'h00}, 1'b0);
    wait_ev(5);
    for (int i = 0; i < 2; i++) begin
      r = rnd();
      position_error_i <= r[7:0];
      repeat (4) @(posedge clk_i);
      pulse(3);
      wait_ev(3);
      repeat (8) @(posedge clk_i);
      chk("correction", r[7:0], correction_o);
      wait_ev(1);
    end
    send({8'h80, 8'h05, 16'h0}, 1'b0);
    wait_ev(0);
    pulse(1);
    wait_ev(1);
    chk("corr cleared", 32'h0, correction_valid_o);
    send({8'h80, 8'h0a, 16'h0}, 1'b1);
    wait_ev(4);
    repeat (20) @(posedge clk_i);
    chk("rejected", 32'h7, status_o);
    send(32'h0, 1'b0);
    wait_ev(7);
    for (int b = 0; b < 9; b++) begin
      repeat (b ? 16 : 8) @(posedge clk_i);
      r[b] = serial_tx_o;
    end
    chk("reply", 32'h00e, r[8:0]);
    wait_ev(1);
    chk("cleared", 32'h6, status_o);
    pulse(0);
    wait_ev(0);
    chk("recovery", 32'h3048, move_o);
    pulse(1);
    wait_ev(1);
    chk("recovered", 32'h7, status_o);
    send(32'h0, 1'b0);
    wait_ev(5);
    wait_ev(1);
    pulse(0);
    wait_ev(0);
    pulse(2);
    wait_ev(0);
    pulse(2);
    wait_ev(0);
    chk("park", 32'h4, move_o.kind);
    pulse(1);
    wait_ev(1);
    chk("undetented", 32'h0, detent_o);
    end_of_test();
  end
endmodule
bind svc_top svc_monitor i_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .index_i,
  .status_o, .move_start_o, .move_o, .detent_o, .offset_step_o, .correction_valid_o);
`default_nettype wire
